// ===== logic/status_block_defines.svh
`ifndef STATUS_BLOCK_DEFINES_SVH
`define STATUS_BLOCK_DEFINES_SVH
// record byte offsets
`define REC_OFS_ID 8'h00
`define REC_OFS_STAT 8'h04
`define REC_OFS_SNS0 8'h08
`define REC_OFS_SNS1 8'h0C
`define REC_STRIDE 32'h0000_0010
// flag byte bit positions
`define FLG_DONE 7
`define FLG_ERR 6
`define FLG_RETRY 5
`define FLG_SHORT 4
`define FLG_OVER 3
`define FLG_CONT 2
`define FLG_TGT 0
// status byte
`define ST_CODE_MSK 8'h3E
`define ST_CHECK 8'h02
`define ERR_UNEXP_PHASE 8'h24
`define ERR_NONE 8'h00
// sense
`define SNS_MAX_SEQ 6'd32
`define SNS_MAX_SEL 5'd16
`define SNS_DEFAULT 6'd8
`define SNS_PER_REC 6'd8
// register offsets
`define A_CTRL 8'h00
`define A_STATUS 8'h04
`define A_CMD_ID 8'h08
`define A_BASE 8'h0C
`define A_XFER 8'h10
`define A_SNS_CNT 8'h14
`define A_SEL0 8'h18
`define A_RECS 8'h28
`define A_SNS0 8'h40
`define A_SEL_LAST 8'h24
`define A_SNS_LAST 8'h7C
`endif

// ===== logic/status_block_pkg.sv
package status_block_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WID = 5'b00010,
    ST_WSTAT = 5'b00100,
    ST_WSNS = 5'b01000,
    ST_WAIT = 5'b10000
  } wr_state_e;
endpackage

// ===== logic/status_block_builder.sv
`include "status_block_defines.svh"
module status_block_builder (
  input wire logic core_clk_in, // 50 MHz clock
  input wire logic sys_rst_in, // async reset, high
  input wire logic [7:0] s_axi_awaddr_in, // write address
  input wire logic s_axi_awvalid_in, // write address valid
  output logic s_axi_awready_out, // write address ready
  input wire logic [31:0] s_axi_wdata_in, // write data
  input wire logic [3:0] s_axi_wstrb_in, // byte strobes
  input wire logic s_axi_wvalid_in, // write data valid
  output logic s_axi_wready_out, // write data ready
  output logic [1:0] s_axi_bresp_out, // write response
  output logic s_axi_bvalid_out, // write response valid
  input wire logic s_axi_bready_in, // write response ready
  input wire logic [7:0] s_axi_araddr_in, // read address
  input wire logic s_axi_arvalid_in, // read address valid
  output logic s_axi_arready_out, // read address ready
  output logic [31:0] s_axi_rdata_out, // read data
  output logic [1:0] s_axi_rresp_out, // read response
  output logic s_axi_rvalid_out, // read data valid
  input wire logic s_axi_rready_in, // read data ready
  output logic [31:0] mem_addr_out, // record word address
  output logic [31:0] mem_data_out, // record word data
  output logic mem_valid_out, // record word valid
  input wire logic mem_ready_in, // memory took word
  output logic sense_req_out // request sense level
);
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic busy;
    logic sense_req;
    logic [31:0] cmd_id;
    logic [31:0] base;
    logic [7:0] flags_in;
    logic [7:0] err_code;
    logic [7:0] tgt_stat;
    logic [2:0] phase;
    logic [31:0] xfer_cnt;
    logic [31:0] moved_cnt;
    logic [5:0] sns_cnt;
    logic [31:0][7:0] sns;
    logic [15:0][7:0] sel;
    logic [5:0] total;
    logic [5:0] idx;
    logic [7:0] recs;
    logic [7:0] last_flags;
    logic [31:0] addr;
    logic [31:0] data;
    logic valid;
    status_block_pkg::wr_state_e st;
  } state_s;
  state_s q, d;
  // register map as seen over the bus
  //   00 control: bit0 start, bit1 sense inhibit
  //      byte1 completion flags in, byte2 error code
  //      bits 26:24 phase lines msg, c/d, i/o
  //      read: bit0 busy
  //   04 target status byte, read back with last flag byte
  //   08 command identifier
  //   0c record base byte address
  //   10 programmed transfer count
  //   14 sense count in 5:0, bytes moved in 31:16
  //   18..24 sixteen selected sense byte numbers
  //   28 records written so far, read only
  //   40..7c thirty-two sense bytes from the target
  // record series sequencing
  //   each record is four words: id, sense lo, sense hi, flags
  //   the flag word goes last so a poller never sees a torn record
  //   record k sits at base plus sixteen times k
  //   eight sense bytes per record, lane n%4 holds byte n
  //   chained records repeat id, status and error; their flags also set the continue bit
  // hazards
  //   start while busy is ignored, fields must be set beforehand
  //   busy drops only once the final flag word is in memory
  //   the output word stays still until memory takes it
  // base of the record being written, from the byte counter
  logic [31:0] rec_base;
  assign rec_base = 32'(q.base + {25'h000_0000, q.idx, 1'b0});
  // selected-mode count: slots up to and including the last nonzero one
  logic [4:0] sel_n;
  logic [15:0] sel_nz;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_sel
      assign sel_nz[gi] = (q.sel[gi] != 8'h00);
    end
  endgenerate
  always_comb begin
    sel_n = 5'd0;
    for (int i = 0; i < 16; i++) begin
      if (sel_nz[i]) begin
        sel_n = 5'(i + 1);
      end
    end
  end
  logic [7:0] cur_flags;
  logic [7:0] cur_stat;
  logic [7:0] sbyte [4];
  logic check_cond;
  logic unexp;
  assign check_cond = (q.tgt_stat & `ST_CODE_MSK) == `ST_CHECK;
  assign unexp = q.err_code == `ERR_UNEXP_PHASE;
  // status field: phase on unexpected phase, else target code
  assign cur_stat = unexp ? {5'h00, q.phase}
                          : (q.tgt_stat & `ST_CODE_MSK);
  always_comb begin
    cur_flags = 8'h00;
    cur_flags[`FLG_DONE] = 1'b1;
    cur_flags[`FLG_ERR] = q.err_code != `ERR_NONE;
    cur_flags[`FLG_RETRY] = q.flags_in[`FLG_RETRY];
    cur_flags[`FLG_SHORT] = q.moved_cnt < q.xfer_cnt;
    cur_flags[`FLG_OVER] = q.flags_in[`FLG_OVER];
    cur_flags[`FLG_CONT] = q.idx != 6'd0;
    cur_flags[`FLG_TGT] = 1'b0;
  end
  // pick sense byte for slot k of the current record
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      logic [5:0] n;
      // second sense word carries bytes four to seven of the record
      n = 6'(q.idx + 6'(k) + (q.st == status_block_pkg::ST_WAIT ? 6'd4 : 6'd0));
      sbyte[k] = 8'h00;
      if (q.total != 6'd0 && n < q.total) begin
        if (q.sns_cnt == 6'd0 && sel_n != 5'd0) begin
          sbyte[k] = q.sns[q.sel[n[3:0]][4:0]];
        end else begin
          sbyte[k] = q.sns[n[4:0]];
        end
      end
    end
  end
  always_comb begin
    d = q;
    // write channel
    if (s_axi_awvalid_in && !q.aw_got) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !q.w_got) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata_in;
      d.wstrb = s_axi_wstrb_in;
    end
    if (s_axi_bvalid_out && s_axi_bready_in) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = 2'b00;
      if (q.awaddr == `A_CTRL) begin
        if (q.wstrb[0] && q.wdata[0] && !q.busy) begin
          d.busy = 1'b1;
          d.idx = 6'd0;
          d.sense_req = 1'b0;
          // zero sense unless check and not inhibited
          if (!check_cond || q.wdata[1]) begin
            d.total = 6'd0;
          end else if (q.sns_cnt != 6'd0) begin
            d.total = q.sns_cnt > `SNS_MAX_SEQ ? `SNS_MAX_SEQ : q.sns_cnt;
            d.sense_req = 1'b1;
          end else if (sel_n != 5'd0) begin
            d.total = {1'b0, sel_n};
            d.sense_req = 1'b1;
          end else begin
            d.total = `SNS_DEFAULT;
            d.sense_req = 1'b1;
          end
          d.st = status_block_pkg::ST_WID;
          d.addr = q.base;
        end
        if (q.wstrb[1]) begin
          d.flags_in = q.wdata[15:8];
          d.err_code = q.wdata[23:16];
          d.phase = q.wdata[26:24];
        end
      end else if (q.awaddr == `A_STATUS) begin
        if (q.wstrb[0]) d.tgt_stat = q.wdata[7:0];
      end else if (q.awaddr == `A_CMD_ID) begin
        d.cmd_id = q.wdata;
      end else if (q.awaddr == `A_BASE) begin
        d.base = q.wdata;
      end else if (q.awaddr == `A_XFER) begin
        d.xfer_cnt = q.wdata;
      end else if (q.awaddr == `A_SNS_CNT) begin
        d.sns_cnt = q.wdata[5:0];
        d.moved_cnt = {16'h0000, q.wdata[31:16]};
      end else if (q.awaddr >= `A_SEL0 && q.awaddr <= `A_SEL_LAST) begin
        for (int j = 0; j < 4; j++) begin
          if (q.wstrb[j]) begin
            d.sel[4'({q.awaddr[3:2] - 2'd2, 2'(j)})] = q.wdata[j*8 +: 8];
          end
        end
      end else if (q.awaddr >= `A_SNS0 && q.awaddr <= `A_SNS_LAST) begin
        for (int j = 0; j < 4; j++) begin
          if (q.wstrb[j]) begin
            d.sns[5'({q.awaddr[4:2], 2'(j)})] = q.wdata[j*8 +: 8];
          end
        end
      end else begin
        d.bresp = 2'b10;
      end
    end
    // read channel
    if (s_axi_rvalid_out && s_axi_rready_in) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp = 2'b00;
      case (s_axi_araddr_in)
        `A_CTRL: begin
          d.rdata = {5'h00, q.phase, q.err_code, q.flags_in, 7'h00, q.busy};
        end
        `A_STATUS: begin
          d.rdata = {16'h0000, q.last_flags, q.tgt_stat};
        end
        `A_CMD_ID: begin
          d.rdata = q.cmd_id;
        end
        `A_BASE: begin
          d.rdata = q.base;
        end
        `A_XFER: begin
          d.rdata = q.xfer_cnt;
        end
        `A_SNS_CNT: begin
          d.rdata = {q.moved_cnt[15:0], 10'h000, q.sns_cnt};
        end
        `A_RECS: begin
          d.rdata = {24'h00_0000, q.recs};
        end
        default: begin
          // unmapped: slave error, data zero
          d.rdata = 32'h0000_0000;
          d.rresp = 2'b10;
        end
      endcase
    end
    // record writer; each word waits for mem_ready
    if (q.valid && mem_ready_in) begin
      d.valid = 1'b0;
    end
    if (!q.valid || mem_ready_in) begin
      case (q.st)
        status_block_pkg::ST_WID: begin
          // identifier word first
          d.addr = 32'(rec_base + {24'h00_0000, `REC_OFS_ID});
          d.data = q.cmd_id;
          d.valid = 1'b1;
          d.st = status_block_pkg::ST_WSNS;
        end
        status_block_pkg::ST_WSNS: begin
          // sense bytes zero to three of this record
          d.addr = 32'(rec_base + {24'h00_0000, `REC_OFS_SNS0});
          d.data = {sbyte[3], sbyte[2], sbyte[1], sbyte[0]};
          d.valid = 1'b1;
          d.st = status_block_pkg::ST_WAIT;
        end
        status_block_pkg::ST_WAIT: begin
          // sense bytes four to seven of this record
          d.addr = 32'(rec_base + {24'h00_0000, `REC_OFS_SNS1});
          d.data = {sbyte[3], sbyte[2], sbyte[1], sbyte[0]};
          d.valid = 1'b1;
          d.st = status_block_pkg::ST_WSTAT;
        end
        status_block_pkg::ST_WSTAT: begin
          // flag word last so polled done never shows a partial record
          d.addr = 32'(rec_base + {24'h00_0000, `REC_OFS_STAT});
          d.data = {cur_flags, q.err_code, cur_stat, 8'h00};
          d.valid = 1'b1;
          d.last_flags = cur_flags;
          d.recs = 8'(q.recs + 8'd1);
          if (6'(q.idx + `SNS_PER_REC) < q.total) begin
            d.idx = 6'(q.idx + `SNS_PER_REC);
            d.st = status_block_pkg::ST_WID;
          end else begin
            d.st = status_block_pkg::ST_IDLE;
          end
        end
        status_block_pkg::ST_IDLE: begin
          // last flag word taken: the series is complete
          if (q.busy) begin
            d.busy = 1'b0;
            d.sense_req = 1'b0;
          end
        end
        default: d.st = status_block_pkg::ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '0;
      q.st <= status_block_pkg::ST_IDLE;
    end else begin
      q <= d;
    end
  end
  assign s_axi_awready_out = !q.aw_got;
  assign s_axi_wready_out = !q.w_got;
  assign s_axi_bvalid_out = q.bvalid;
  assign s_axi_bresp_out = q.bresp;
  assign s_axi_arready_out = !q.rvalid;
  assign s_axi_rvalid_out = q.rvalid;
  assign s_axi_rdata_out = q.rdata;
  assign s_axi_rresp_out = q.rresp;
  // record word port, held until memory takes the word
  assign mem_addr_out = q.addr;
  assign mem_data_out = q.data;
  assign mem_valid_out = q.valid;
  assign sense_req_out = q.sense_req;
endmodule

// ===== sim/status_block_builder_chk.sv
module status_block_builder_chk (
  input wire logic core_clk_in, // clock
  input wire logic sys_rst_in, // reset
  input wire logic s_axi_arvalid_in, // read addr valid
  input wire logic s_axi_arready_out, // read addr ready
  input wire logic s_axi_rvalid_out, // read data valid
  input wire logic [31:0] mem_addr_out, // word address
  input wire logic [31:0] mem_data_out, // word data
  input wire logic mem_valid_out, // word valid
  input wire logic mem_ready_in, // word taken
  input wire logic sense_req_out // sense active
);
  logic [3:0] last_q;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // offset of the word last taken by memory
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) last_q <= 4'h4;
    else if (mem_valid_out && mem_ready_in) last_q <= mem_addr_out[3:0];
  end
  sequence s_flag_word;
    mem_valid_out && mem_addr_out[3:0] == 4'h4;
  endsequence
  sequence s_sense_word;
    mem_valid_out && mem_addr_out[3];
  endsequence
  property p_hold;
    mem_valid_out && !mem_ready_in |=> mem_valid_out &&
      $stable(mem_addr_out) && $stable(mem_data_out);
  endproperty
  property p_flag_low;
    s_flag_word |-> mem_data_out[25:24] == 2'b00;
  endproperty
  property p_done;
    s_flag_word |-> mem_data_out[31];
  endproperty
  property p_flag_last;
    s_flag_word |-> last_q == 4'hC;
  endproperty
  property p_err_flag;
    s_flag_word |-> mem_data_out[30] == (mem_data_out[23:16] != 8'h00);
  endproperty
  property p_sense_zero;
    s_sense_word and !sense_req_out |-> mem_data_out == 32'h0000_0000;
  endproperty
  property p_align;
    mem_valid_out |-> mem_addr_out[1:0] == 2'b00;
  endproperty
  property p_id_first;
    mem_valid_out && mem_addr_out[3:0] == 4'h0 |-> last_q == 4'h4;
  endproperty
  property p_read_ans;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
  endproperty
  a_hold: assert property (p_hold) else $error("word dropped early");
  a_flag_low: assert property (p_flag_low) else $error("bits 1:0 set");
  a_done: assert property (p_done) else $error("done flag low");
  a_flag_last: assert property (p_flag_last) else $error("flags early");
  a_err_flag: assert property (p_err_flag) else $error("error flag");
  a_sense_zero: assert property (p_sense_zero) else $error("sense");
  a_align: assert property (p_align) else $error("unaligned word");
  a_id_first: assert property (p_id_first) else $error("id order");
  a_read_ans: assert property (p_read_ans) else $error("read late");
endmodule
bind status_block_builder status_block_builder_chk i_chk (.core_clk_in,
  .sys_rst_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
  .mem_addr_out, .mem_data_out, .mem_valid_out, .mem_ready_in,
  .sense_req_out);

// ===== sim/record_mem_model.sv
module record_mem_model (
  input wire logic clk_in, // clock
  input wire logic [31:0] addr_in, // byte address
  input wire logic [31:0] data_in, // word data
  input wire logic valid_in, // word offered
  input wire logic slow_in, // stall three of four cycles
  output logic ready_out // word taken
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [logic [31:0]];
  logic [1:0] cnt_q = 2'b00;
  assign ready_out = !slow_in || cnt_q == 2'b11;
  always @(posedge clk_in) begin
    cnt_q <= cnt_q + 2'd1;
    if (valid_in && ready_out) mem[addr_in] = data_in;
  end
endmodule

// ===== sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic awr, wr_rdy, bv, arr, rv, mv, mr, sreq, slow = 1'b0, saw = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00, st, err;
  logic [31:0] wd = 32'h0000_0000, rd_d, ma, md, cid, base, xfer, v;
  logic [1:0] br, rr, r;
  logic [15:0] moved;
  logic [5:0] cnt;
  logic [2:0] ph;
  logic retried_flag, ovr, inh;
  logic [7:0] sns [32];
  logic [7:0] sel [16];
  logic [7:0] nc [7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h28};
  int fail_count = 0, checks = 0, cyc = 0, seed = 8;
  status_block_builder i_status_block_builder (.core_clk_in(clk),
    .sys_rst_in(rst), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_rdy), .s_axi_bresp_out(br),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(1'b1), .s_axi_araddr_in(ara),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd_d),
    .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(1'b1),
    .mem_addr_out(ma), .mem_data_out(md), .mem_valid_out(mv),
    .mem_ready_in(mr), .sense_req_out(sreq));
  record_mem_model i_record_mem_model (.clk_in(clk), .addr_in(ma),
    .data_in(md), .valid_in(mv), .slow_in(slow), .ready_out(mr));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (sreq) saw <= 1'b1;
    if (cyc == 30000) begin
      fail_count++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // ready and valid are sampled mid-cycle, acted on at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int n;
    n = 0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wr_rdy;
      tb = bv;
      r = br;
      n++;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!tb && n < 50);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    int n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    do begin
      @(negedge clk);
      ta = arv && arr;
      tr = rv;
      v = rd_d;
      r = rr;
      n++;
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end while (!tr && n < 50);
  endtask
  function automatic logic [31:0] expw(int k, int w);
    logic [7:0] b [4];
    int i;
    if (w == 0) return cid;
    if (w == 1) return {1'b1, err != 8'h00, retried_flag, moved < xfer, ovr, k != 0,
      2'b00, err, err == 8'h24 ? {5'h00, ph} : st, 8'h00};
    for (int j = 0; j < 4; j++) begin
      i = k * 8 + (w - 2) * 4 + j;
      b[j] = (st == 8'h02 && !inh) ? sns[sel[0] != 0 ? sel[i][4:0] : i] : 0;
    end
    return {b[3], b[2], b[1], b[0]};
  endfunction
  task automatic run(input int i);
    int mode, nrec, n;
    logic [31:0] mk;
    mode = i < 8 ? i : 4;
    cid = $random(seed);
    base = 32'h0000_1000 * (i + 1);
    xfer = {$random(seed)} % 512 + 1;
    moved = {$random(seed)} % 600;
    {retried_flag, ovr, ph} = $random(seed);
    st = (mode < 4 || mode == 5) ? 8'h02 : nc[i % 7];
    inh = mode == 5;
    err = mode == 6 ? 8'h24 : (mode == 7 ? 8'h11 : 8'h00);
    cnt = mode == 1 ? 6'd32 : (mode == 2 ? 6'd16 : 6'd0);
    for (int j = 0; j < 16; j++) sel[j] = mode == 3 ? 1 + {$random(seed)} % 31 : 0;
    for (int j = 0; j < 32; j++) sns[j] = $random(seed);
    slow <= i[0];
    wr(8'h08, cid);
    wr(8'h04, {24'h00_0000, st});
    wr(8'h0C, base);
    wr(8'h10, xfer);
    wr(8'h14, {moved, 10'h000, cnt});
    for (int j = 0; j < 4; j++)
      wr(8'h18 + 4 * j, {sel[4*j+3], sel[4*j+2], sel[4*j+1], sel[4*j]});
    for (int j = 0; j < 8; j++)
      wr(8'h40 + 4 * j, {sns[4*j+3], sns[4*j+2], sns[4*j+1], sns[4*j]});
    saw = 1'b0;
    wr(8'h00, {5'h00, ph, err, 2'b00, retried_flag, 1'b0, ovr, 9'h000, inh, 1'b1});
    n = 0;
    do begin
      rd(8'h00);
      n++;
    end while (v[0] !== 1'b0 && n < 300);
    nrec = (st == 8'h02 && !inh) ? (cnt != 0 ? cnt / 8 : (mode == 3 ? 2 : 1)) : 1;
    chk(saw, st == 8'h02 && !inh, "sense request");
    for (int k = 0; k < nrec; k++)
      for (int w = 0; w < 4; w++) begin
        mk = (w == 1 && err == 8'h24) ? 32'hFFFF_07FF : 32'hFFFF_FFFF;
        chk(i_record_mem_model.mem[base + 16 * k + 4 * w] & mk, expw(k, w) & mk,
          "record word");
      end
    chk(i_record_mem_model.mem.exists(base + 16 * nrec), 0, "extra record");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h30);
    chk({v, r}, 34'h2, "unmapped read");
    wr(8'h30, 32'h0000_00FF);
    chk(r, 2'b10, "unmapped write");
    for (int i = 0; i < 14; i++) run(i);
    results();
  end
endmodule
